/* pkg/dkc_pkg.sv */
// constants, state codes and carriers for the 1k x 1 dynamic memory cycle controller
// assumes a 100 MHz system clock; the memory itself has no clock
//
// Contract
// - read: address presented, read/write select high
// - write: low select pulse stores input data
// - read-modify-write: data read before write pulse
// - refresh is read cycle on low five lines
// - every row refreshed within 2 ms
// - read cycles start no closer than 480 ns
// - write and read-modify-write cycles take 580 ns
package dkc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned ROW_W = 5;
  localparam int unsigned WORDS = 1024;
  // cycle minima in ns, counts round up
  localparam int unsigned T_RD_NS = 480;
  localparam int unsigned T_WR_NS = 580;
  localparam int unsigned T_RD_CYC = (T_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_WR_CYC = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // refresh period 2 ms, spread over 32 rows, longest rounds down
  localparam int unsigned T_REF_NS = 2000000;
  localparam int unsigned T_REF_CYC = T_REF_NS / CLK_PERIOD_NS;
  localparam int unsigned REF_INT_CYC = T_REF_CYC / (1 << ROW_W) - T_WR_CYC * 2;
  // phase marks inside one cycle, in clocks from start
  localparam logic [7:0] PH_CE_ON = 8'h0D;
  localparam logic [7:0] PH_SAMPLE = 8'h1F;
  localparam logic [7:0] PH_WR_ON = 8'h20;
  localparam logic [7:0] PH_WR_OFF = 8'h26;
  localparam logic [7:0] PH_PRE_OFF = 8'h14;
  localparam logic [7:0] PH_CE_OFF = 8'h28;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_RMW = 2'h2;
  localparam logic [1:0] OP_REFR = 2'h3;

  typedef enum logic [1:0] {
    DKC_IDLE = 2'b00,
    DKC_RUN = 2'b01,
    DKC_DONE = 2'b10
  } dkc_state_e;

  // request from the user side
  typedef struct packed {
    logic [1:0] op;
    logic [ADDR_W-1:0] addr;
    logic wdata;
  } dkc_req_s;

  // pins toward the memory
  typedef struct packed {
    logic pre;
    logic ce;
    logic rw;
    logic [ADDR_W-1:0] word_address;
    logic din;
  } dkc_pins_s;
endpackage : dkc_pkg

/* rtl/dkc_refresh_timer.sv */
// refresh pacing: raises a request every interval, steps the row
// assumes the main controller acknowledges with a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module dkc_refresh_timer #(
  parameter int unsigned INTERVAL = dkc_pkg::REF_INT_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ack_i,
  output logic req_o,
  output logic [dkc_pkg::ROW_W-1:0] row_o
);
  import dkc_pkg::*;
  logic [17:0] cnt_r; // interval countdown
  logic expired; // interval elapsed
  assign expired = (cnt_r == 18'h00000);

  // count down, request stays until served; set beats ack
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_r <= 18'h00000;
      req_o <= 1'b0;
      row_o <= '0;
    end else begin
      cnt_r <= expired ? 18'(INTERVAL - 1) : cnt_r - 18'h00001;
      if (expired) begin
        req_o <= 1'b1;
      end else if (ack_i) begin
        req_o <= 1'b0;
      end
      if (ack_i) begin
        row_o <= row_o + {{(ROW_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule : dkc_refresh_timer
`default_nettype wire

/* rtl/dkc_ctrl.sv */
// host side controller for a 1k x 1 dynamic memory: runs read, write,
// read-modify-write and refresh cycles on the strobes
// assumes memory pins are asynchronous; dout passes two flops
`timescale 1ns/100ps
`default_nettype none
module dkc_ctrl #(
  parameter int unsigned REF_INTERVAL = dkc_pkg::REF_INT_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic req_valid_i,
  input wire dkc_pkg::dkc_req_s req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic rsp_data_o,
  output dkc_pkg::dkc_pins_s pins_o,
  input wire logic dout_i
);
  import dkc_pkg::*;

  dkc_state_e state_r; // cycle state
  logic [7:0] ph_r; // phase counter within a cycle
  logic [1:0] op_r; // op in flight
  logic [ADDR_W-1:0] addr_r; // latched address
  logic wdata_r; // latched write data
  logic rdata_r; // captured read bit
  logic dout_s1_r; // synchroniser stage 1
  logic dout_s2_r; // synchroniser stage 2
  logic ref_req; // refresh due
  logic ref_ack; // refresh granted
  logic [ROW_W-1:0] ref_row; // next row
  logic start_ref; // begin refresh cycle
  logic start_usr; // begin user cycle
  logic [7:0] cyc_len; // minimum span of the op
  logic writes; // op has write pulse
  logic cyc_end; // last phase reached
  logic pre_on; // precharge strobe window
  logic ce_on; // chip enable window
  logic wr_on; // write pulse window

  dkc_refresh_timer #(.INTERVAL(REF_INTERVAL)) u_ref (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ack_i(ref_ack),
    .req_o(ref_req),
    .row_o(ref_row)
  );

  // refresh wins over user requests when both wait
  assign start_ref = (state_r == DKC_IDLE) && ref_req;
  assign start_usr = (state_r == DKC_IDLE) && !ref_req && req_valid_i;
  assign ref_ack = start_ref;
  assign writes = (op_r == OP_WRITE) || (op_r == OP_RMW);
  // read and refresh spaced 480 ns, writes 580 ns
  assign cyc_len = writes ? 8'(T_WR_CYC) : 8'(T_RD_CYC);
  assign cyc_end = (state_r == DKC_RUN) && (ph_r == cyc_len - 8'h01);
  // precharge first, chip enable after, both released before the end
  assign pre_on = (state_r == DKC_RUN) && (ph_r < PH_PRE_OFF);
  assign ce_on = (state_r == DKC_RUN) && (ph_r >= PH_CE_ON) && (ph_r < PH_CE_OFF);
  // write pulse low after the read sample, so rmw sees old data
  assign wr_on = ce_on && writes && (ph_r >= PH_WR_ON) && (ph_r < PH_WR_OFF);

  // dout crosses in from the pin
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dout_s1_r <= 1'b0;
      dout_s2_r <= 1'b0;
    end else begin
      dout_s1_r <= dout_i;
      dout_s2_r <= dout_s1_r;
    end
  end

  // cycle sequencer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_r <= DKC_IDLE;
      ph_r <= 8'h00;
      op_r <= OP_READ;
      addr_r <= '0;
      wdata_r <= 1'b0;
      rdata_r <= 1'b0;
    end else begin
      unique case (state_r)
        DKC_IDLE: begin
          ph_r <= 8'h00;
          if (start_ref) begin
            op_r <= OP_REFR;
            addr_r <= {{(ADDR_W-ROW_W){1'b0}}, ref_row};
            state_r <= DKC_RUN;
          end else if (start_usr) begin
            op_r <= req_i.op;
            addr_r <= req_i.addr;
            wdata_r <= req_i.wdata;
            state_r <= DKC_RUN;
          end
        end
        DKC_RUN: begin
          ph_r <= ph_r + 8'h01;
          // read data valid before any write pulse
          if (ph_r == PH_SAMPLE) begin
            rdata_r <= dout_s2_r;
          end
          if (cyc_end) begin
            state_r <= DKC_DONE;
          end
        end
        DKC_DONE: begin
          state_r <= DKC_IDLE;
        end
        default: begin
          state_r <= DKC_IDLE;
        end
      endcase
    end
  end

  // registered outputs; dout is only driven while ce is active
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pins_o <= '{pre: 1'b0, ce: 1'b0, rw: 1'b1, word_address: '0, din: 1'b0};
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 1'b0;
    end else begin
      pins_o.pre <= pre_on;
      pins_o.ce <= ce_on;
      pins_o.rw <= !wr_on;
      pins_o.word_address <= addr_r;
      pins_o.din <= wdata_r;
      req_ready_o <= start_usr;
      rsp_valid_o <= cyc_end && (op_r != OP_REFR) && (op_r != OP_WRITE);
      rsp_data_o <= rdata_r;
    end
  end

  // spacing counter for checks
  logic [9:0] gap_r;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      gap_r <= 10'h3FF;
    end else begin
      gap_r <= (start_ref || start_usr) ? 10'h000 : ((gap_r == 10'h3FF) ? gap_r : gap_r + 10'h001);
    end
  end

  chk_read_spacing: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (start_ref || start_usr) |-> gap_r >= 10'(T_RD_CYC))
    else $error("cycle started too soon");
  chk_write_length: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (start_ref || start_usr) && writes && $past(state_r) == DKC_DONE |-> gap_r >= 10'(T_WR_CYC))
    else $error("write cycle too short");
  chk_pre_before_ce: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(pins_o.ce) |-> pins_o.pre && $past(pins_o.pre, 2))
    else $error("chip enable without precharge");
  chk_write_in_ce: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !pins_o.rw |-> pins_o.ce && $stable(pins_o.din))
    else $error("write pulse outside chip enable");
  chk_sample_first: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(pins_o.rw) |-> $past(ph_r) > PH_SAMPLE)
    else $error("write before read sample");
  chk_refresh_row: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    start_ref |=> addr_r[ADDR_W-1:ROW_W] == '0 && op_r == OP_REFR)
    else $error("refresh address wrong");
  chk_refresh_served: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(ref_req) |-> ##[0:80] ref_ack)
    else $error("refresh starved");
  chk_idle_released: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_r == DKC_DONE |=> !pins_o.ce && !pins_o.pre && pins_o.rw)
    else $error("strobes held across cycles");
  chk_read_rw_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_r == DKC_RUN && !writes |=> pins_o.rw)
    else $error("read cycle pulsed write");
  chk_addr_stable: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    pins_o.ce && $past(pins_o.ce) |-> $stable(pins_o.word_address))
    else $error("address moved under chip enable");

  cov_read: cover property (@(posedge clk_i) rsp_valid_o && op_r == OP_READ);
  cov_rmw: cover property (@(posedge clk_i) rsp_valid_o && op_r == OP_RMW);
  cov_refresh: cover property (@(posedge clk_i) start_ref);
  cov_ref_vs_usr: cover property (@(posedge clk_i) start_ref && req_valid_i);
endmodule : dkc_ctrl
`default_nettype wire

/* verification/dkc_mem_model.sv */
// behavioural 1k x 1 dynamic memory plus a watch on the controller's timing
// assumes its pins come from registers clocked by clk_i
`timescale 1ns/100ps
`default_nettype none
module dkc_mem_model
  import dkc_pkg::*;
#(
  parameter int REF_LIM = 8640
) (
  input wire logic clk_i,
  input wire dkc_pkg::dkc_pins_s pins_i,
  output logic dout_o,
  output int fault_o
);
  logic mem_r [WORDS]; // cell array, one bit a word
  logic float_r; // stands in for an undriven wire
  logic ce_q, pre_q; // previous pin levels
  int now, start_t, min_gap;
  int stamp [1 << ROW_W]; // last restore time of each row
  initial begin
    foreach (mem_r[i]) mem_r[i] = 1'b0;
    foreach (stamp[i]) stamp[i] = 0;
    {float_r, ce_q, pre_q} = 3'h0;
    fault_o = 0;
    now = 0;
    start_t = -1000;
    min_gap = 0;
  end
  // data out only while enabled; old bit shows until the write pulse
  assign dout_o = pins_i.ce ? mem_r[pins_i.word_address] : float_r;
  // float toggles every clock so a stale sample never looks right
  always @(posedge clk_i) begin
    now++;
    float_r <= ~float_r;
    if (pins_i.pre && !pre_q) begin
      if (now - start_t < min_gap) fault_o++;
      if (ce_q) fault_o++;
      start_t = now;
      min_gap = T_RD_CYC;
    end
    // any enabled cycle restores its row
    if (pins_i.ce && !ce_q) stamp[pins_i.word_address[ROW_W-1:0]] = now;
    // low select pulse stores din
    if (pins_i.ce && !pins_i.rw) begin
      mem_r[pins_i.word_address] = pins_i.din;
      min_gap = T_WR_CYC;
    end
    foreach (stamp[i]) if (now - stamp[i] > REF_LIM) fault_o++;
    ce_q = pins_i.ce;
    pre_q = pins_i.pre;
  end
endmodule : dkc_mem_model
`default_nettype wire

/* verification/dkc_ctrl_tb.sv */
// self-checking bench for the dynamic memory cycle controller
// assumes the memory model answers on dout and counts timing faults
`timescale 1ns/100ps
`default_nettype none
module dkc_ctrl_tb;
  import dkc_pkg::*;
  localparam int REF_IV = 200; // shortened refresh spacing
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  dkc_req_s req_i = '0;
  logic req_ready_o, rsp_valid_o, rsp_data_o, dout_i;
  dkc_pins_s pins_o;
  int fault_cnt;
  int err_total = 0;
  int compares = 0;
  logic exp_mem [WORDS]; // expected contents
  always #5 clk_i = ~clk_i;
  dkc_ctrl #(.REF_INTERVAL(REF_IV)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .pins_o(pins_o), .dout_i(dout_i));
  dkc_mem_model #(.REF_LIM(32 * (REF_IV + 2 * T_WR_CYC))) mem (.clk_i(clk_i), .pins_i(pins_o),
    .dout_o(dout_i), .fault_o(fault_cnt));
  // compare one bit, four-state
  task check(input string what, input logic seen, input logic exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %b seen %b", what, exp, seen);
    end
  endtask : check
  task print_verdict;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // a response is due for read and read-modify-write only
  function logic rsp_due(input logic [1:0] op);
    return (op == OP_READ) || (op == OP_RMW);
  endfunction : rsp_due
  // one request, held until accepted, then its response window
  task run_op(input logic [1:0] op, input logic [ADDR_W-1:0] a, input logic wd);
    int n;
    logic got;
    @(posedge clk_i);
    #1;
    req_i.op = op;
    req_i.addr = a;
    req_i.wdata = wd;
    req_valid_i = 1'b1;
    n = 0;
    // ready is a one-cycle pulse: look just after the edge that launches it
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (req_ready_o !== 1'b1 && n < 400);
    req_valid_i = 1'b0;
    check("req_ready_o", req_ready_o, 1'b1);
    got = 1'b0;
    for (n = 0; n < 70 && !got; n++) begin
      @(posedge clk_i);
      #1;
      if (rsp_valid_o === 1'b1) got = 1'b1;
    end
    check("rsp_valid_o", got, rsp_due(op));
    if (got) check("rsp_data_o", rsp_data_o, exp_mem[a]);
    if (op == OP_WRITE || op == OP_RMW) exp_mem[a] = wd;
  endtask : run_op
  initial begin
    logic [1:0] op;
    logic [ADDR_W-1:0] a;
    foreach (exp_mem[i]) exp_mem[i] = 1'b0;
    void'($urandom(9));
    repeat (2) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    // corners: both address ends, old data in rmw, refresh op
    run_op(OP_WRITE, 10'h000, 1'b1);
    run_op(OP_READ, 10'h000, 1'b0);
    run_op(OP_WRITE, 10'h3FF, 1'b1);
    run_op(OP_RMW, 10'h3FF, 1'b0);
    run_op(OP_READ, 10'h3FF, 1'b1);
    run_op(OP_REFR, 10'h01F, 1'b0);
    // random traffic, half of it on addresses 0 to 15 for repeat hits
    repeat (60) begin
      op = 2'($urandom_range(0, 3));
      a = 10'($urandom_range(0, 1) ? $urandom_range(0, 15) : $urandom_range(0, 1023));
      run_op(op, a, 1'($urandom_range(0, 1)));
    end
    check("timing faults", fault_cnt == 0, 1'b1);
    print_verdict();
  end
  // watchdog well beyond the expected run
  initial begin
    #600000;
    err_total++;
    print_verdict();
  end
endmodule : dkc_ctrl_tb
`default_nettype wire
